/* File: verilog/free_running_timer.sv */
/*
 * Free-running 16-bit timer with prescaler, external clock input,
 * two input capture channels and buffered byte reads.
 * Assumes pins synchronous to core_clk and a one-cycle read latency
 * register port. Halt and wait levels come from the power controller.
 */
`timescale 1ns/1ps
module free_running_timer
    import frt_pkg::*;
#(
    parameter bit HAS_EXT_COUNT_CLOCK_PIN = 1'b1,
    parameter bit HAS_CAP2    = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic [3:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    input  wire logic       extCountClockPin,
    input  wire logic       captureInputPin1,
    input  wire logic       captureInputPin2,
    input  wire logic       haltState,
    input  wire logic       waitState,
    input  wire logic       globalIrqMask,
    output logic            timerIrq
);

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [7:0]  firstControlReg;
    logic [7:0]  secondControlReg;
    logic [15:0] count;
    logic [7:0]  lowBuffer;
    logic        lowBuffered;
    logic        overflowFlag;
    logic [1:0]  captureFlag;
    logic [1:0]  captureArmed;
    logic [1:0]  captureBlocked;
    logic [15:0] captureValue [2];
    logic        ovfArmed;
    logic [1:0]  capClearArmed;
    logic [2:0]  prescale;
    logic        extPrev;
    logic [1:0]  capPrev;
    logic [1:0]  extGap;

    wire logic wrAcc = regWr;
    wire logic rdAcc = regRd;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            firstControlReg  <= CTRL_RESET;
            secondControlReg <= CTRL_RESET;
        end else if (wrAcc && regAddr == CTRL1_ADDR) begin
            firstControlReg <= regWrData;
        end else if (wrAcc && regAddr == CTRL2_ADDR) begin
            secondControlReg <= regWrData;
        end
    end

    // ---------------------------------------------------------------
    // input sampling
    // ---------------------------------------------------------------
    // pins not bonded out read as one
    wire logic extIn = HAS_EXT_COUNT_CLOCK_PIN ? extCountClockPin : 1'b1;
    wire logic [1:0] capIn = {HAS_CAP2 ? captureInputPin2 : 1'b1,
                              captureInputPin1};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            extPrev <= 1'b1;
            capPrev <= 2'h3;
        end else begin
            extPrev <= extIn;
            capPrev <= capIn;
        end
    end

    // edges count only once a real sample sits in the previous-value flops;
    // a pin resting low through reset would otherwise fake a falling edge
    logic inputsPrimed;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            inputsPrimed <= 1'b0;
        end else begin
            inputsPrimed <= 1'b1;
        end
    end

    wire logic clkSelHi = secondControlReg[CTRL2_CSHI_BIT];
    wire logic clkSelLo = secondControlReg[CTRL2_CSLO_BIT];
    wire logic extMode  = clkSelHi && clkSelLo;
    wire logic extEdgeSel = secondControlReg[CTRL2_EXT_CLOCK_EDGE_SELECT_BIT];
    // edge select 1 = rising, 0 = falling
    wire logic extEdge = inputsPrimed && (extEdgeSel ? (extIn && !extPrev)
                                                     : (!extIn && extPrev));

    // ---------------------------------------------------------------
    // prescaler and counter
    // ---------------------------------------------------------------
    logic [2:0] divMask;
    always_comb begin
        unique case ({clkSelHi, clkSelLo})
            2'b00:   divMask = DIV4_MASK;
            2'b01:   divMask = DIV2_MASK;
            default: divMask = DIV8_MASK;
        endcase
    end

    // halt freezes the divider too; wait leaves everything running
    wire logic running = !haltState;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prescale <= 3'h0;
        end else if (running) begin
            prescale <= prescale + 3'h1;
        end
    end

    // guard spacing on external edges; the source must keep four cycles
    always_ff @(posedge core_clk) begin
        if (rst) begin
            extGap <= 2'h0;
        end else if (extMode && extEdge && extGap == 2'h0) begin
            extGap <= 2'h3;
        end else if (extGap != 2'h0) begin
            extGap <= extGap - 2'h1;
        end
    end

    wire logic tick = running && (extMode ? (extEdge && extGap == 2'h0)
                                          : ((prescale & divMask) == divMask));
    wire logic cntLoWrite = wrAcc && (regAddr == CNT_LO_ADDR || regAddr == ACNT_LO_ADDR);
    wire logic wrap = tick && count == 16'hffff;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count <= COUNT_RELOAD;
        end else if (cntLoWrite) begin
            count <= COUNT_RELOAD;
        end else if (tick) begin
            count <= count + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // buffered counter read
    // ---------------------------------------------------------------
    wire logic cntHiRd = rdAcc && (regAddr == CNT_HI_ADDR || regAddr == ACNT_HI_ADDR);
    wire logic cntLoRd = rdAcc && (regAddr == CNT_LO_ADDR || regAddr == ACNT_LO_ADDR);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lowBuffered <= 1'b0;
            lowBuffer   <= 8'h00;
        end else if (cntHiRd && !lowBuffered) begin
            lowBuffered <= 1'b1;
            lowBuffer   <= count[7:0];
        end else if (cntLoRd) begin
            lowBuffered <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // overflow flag
    // ---------------------------------------------------------------
    wire logic statusRd = rdAcc && regAddr == STATUS_ADDR;
    // alternate low byte is deliberately absent here
    wire logic primLoAcc = (wrAcc || rdAcc) && regAddr == CNT_LO_ADDR;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ovfArmed <= 1'b0;
        end else if (statusRd) begin
            ovfArmed <= overflowFlag;
        end else if (primLoAcc) begin
            ovfArmed <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            overflowFlag <= 1'b0;
        end else if (wrap) begin
            overflowFlag <= 1'b1;
        end else if (primLoAcc && ovfArmed) begin
            overflowFlag <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // capture channels
    // ---------------------------------------------------------------
    logic [1:0] capEdgeSel;
    assign capEdgeSel = {secondControlReg[CTRL2_EDGE2_BIT],
                         firstControlReg[CTRL1_EDGE1_BIT]};

    for (genvar i = 0; i < 2; i++) begin : gCap
        wire logic [3:0] hiAddr = (i == 0) ? CAP1_HI_ADDR : CAP2_HI_ADDR;
        wire logic [3:0] loAddr = (i == 0) ? CAP1_LO_ADDR : CAP2_LO_ADDR;
        wire logic edgeSeen = inputsPrimed && (capEdgeSel[i] ? (capIn[i] && !capPrev[i])
                                                             : (!capIn[i] && capPrev[i]));
        wire logic hiRd = rdAcc && regAddr == hiAddr;
        wire logic loRd = rdAcc && regAddr == loAddr;
        wire logic loAcc = (rdAcc || wrAcc) && regAddr == loAddr;
        // while blocked the edge is dropped, the old value stays coherent
        wire logic take = edgeSeen && !captureBlocked[i] && !captureArmed[i];
        // halted: arm once, keep the first edge's count, flag at wake
        wire logic wake = captureArmed[i] && !haltState;

        always_ff @(posedge core_clk) begin
            if (rst) begin
                captureBlocked[i] <= 1'b0;
            end else if (hiRd) begin
                captureBlocked[i] <= 1'b1;
            end else if (loRd) begin
                captureBlocked[i] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                captureValue[i] <= 16'h0000;
            end else if (take) begin
                captureValue[i] <= count;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                captureArmed[i] <= 1'b0;
            end else if (take && haltState) begin
                captureArmed[i] <= 1'b1;
            end else if (wake) begin
                captureArmed[i] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                capClearArmed[i] <= 1'b0;
            end else if (statusRd) begin
                capClearArmed[i] <= captureFlag[i];
            end else if (loAcc) begin
                capClearArmed[i] <= 1'b0;
            end
        end

        always_ff @(posedge core_clk) begin
            if (rst) begin
                captureFlag[i] <= 1'b0;
            end else if ((take && !haltState) || wake) begin
                captureFlag[i] <= 1'b1;
            end else if (loAcc && capClearArmed[i]) begin
                captureFlag[i] <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt request
    // ---------------------------------------------------------------
    wire logic ovfReq = overflowFlag && firstControlReg[CTRL1_OVFIE_BIT];
    wire logic capReq = (|captureFlag) && firstControlReg[CTRL1_CAPIE_BIT];
    // flags stay pending while masked, so the line rises once unmasked
    assign timerIrq = (ovfReq || capReq) && !globalIrqMask;

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    logic [7:0] next_rdData;
    always_comb begin
        next_rdData = 8'h00;
        unique case (regAddr)
            CTRL1_ADDR:   next_rdData = firstControlReg;
            CTRL2_ADDR:   next_rdData = secondControlReg;
            STATUS_ADDR: begin
                next_rdData[STAT_CAP1_BIT] = captureFlag[0];
                next_rdData[STAT_CAP2_BIT] = captureFlag[1];
                next_rdData[STAT_OVF_BIT]  = overflowFlag;
            end
            CNT_HI_ADDR,
            ACNT_HI_ADDR: next_rdData = count[15:8];
            CNT_LO_ADDR,
            ACNT_LO_ADDR: next_rdData = lowBuffered ? lowBuffer : count[7:0];
            CAP1_HI_ADDR: next_rdData = captureValue[0][15:8];
            CAP1_LO_ADDR: next_rdData = captureValue[0][7:0];
            CAP2_HI_ADDR: next_rdData = captureValue[1][15:8];
            CAP2_LO_ADDR: next_rdData = captureValue[1][7:0];
            default:      next_rdData = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (rdAcc) begin
            regRdData <= next_rdData;
        end else begin
            regRdData <= 8'h00;
        end
    end

    // waitState has no effect on the timer by design
    logic unusedWait;
    assign unusedWait = waitState;

endmodule : free_running_timer

/* File: verilog/frt_pkg.sv */
/*
 * Constants for the free-running timer with input capture: register
 * offsets, field positions, reset values and prescaler settings.
 * Assumes a byte-wide register port and a single core clock.
 */
// Functional notes
// - 16-bit up-counter, prescaler divides 2/4/8
// - absent timer inputs read as one
// - two count register pairs; alternate keeps flag
// - count low-byte write reloads FFFCh
// - both clock-select bits choose external clock
// - high byte read first latches low byte
// - latched low byte frozen until low read
// - lone low read returns live count
// - wrap FFFFh to 0000h sets overflow flag
// - overflow irq needs enable and clear mask
// - overflow flag clears: status read, low access
// - counter runs on in wait state
// - halt stops counter, resumes held count
// - edge-select bit picks external clock edge
// - external edges synchronised, four cycles apart; code samples the pin unsynchronised
// - capture edge copies count, sets flag
// - per-channel capture edge-select bits
// - capture irq needs enable and clear mask
// - capture flag clears: status read, low read; code also clears on a low-byte write
// - capture high read blocks new transfers
// - capture register holds most recent capture
// - halt capture only arms; flag at wake
package frt_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [3:0] CTRL1_ADDR    = 4'h0;
    localparam logic [3:0] CTRL2_ADDR    = 4'h1;
    localparam logic [3:0] STATUS_ADDR   = 4'h2;
    localparam logic [3:0] CAP1_HI_ADDR  = 4'h3;
    localparam logic [3:0] CAP1_LO_ADDR  = 4'h4;
    localparam logic [3:0] CNT_HI_ADDR   = 4'h5;
    localparam logic [3:0] CNT_LO_ADDR   = 4'h6;
    localparam logic [3:0] ACNT_HI_ADDR  = 4'h7;
    localparam logic [3:0] ACNT_LO_ADDR  = 4'h8;
    localparam logic [3:0] CAP2_HI_ADDR  = 4'h9;
    localparam logic [3:0] CAP2_LO_ADDR  = 4'ha;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int CTRL1_CAPIE_BIT = 7;
    localparam int CTRL1_OVFIE_BIT = 5;
    localparam int CTRL1_EDGE1_BIT = 1;
    localparam int CTRL2_CSHI_BIT  = 3;
    localparam int CTRL2_CSLO_BIT  = 2;
    localparam int CTRL2_EDGE2_BIT = 1;
    localparam int CTRL2_EXT_CLOCK_EDGE_SELECT_BIT = 0;
    localparam int STAT_CAP1_BIT   = 7;
    localparam int STAT_CAP2_BIT   = 4;
    localparam int STAT_OVF_BIT    = 5;

    // ---------------------------------------------------------------
    // reset values and counts
    // ---------------------------------------------------------------
    localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [2:0]  DIV2_MASK    = 3'h1;
    localparam logic [2:0]  DIV4_MASK    = 3'h3;
    localparam logic [2:0]  DIV8_MASK    = 3'h7;

endpackage : frt_pkg

/* File: bench/free_running_timer_monitor.sv */
/* port-level assertions for free_running_timer.
   assumes frt_pkg is compiled first and one core_clk domain. */
`timescale 1ns/1ps
module free_running_timer_monitor
    import frt_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic       extCountClockPin,
    input wire logic       captureInputPin1,
    input wire logic       captureInputPin2,
    input wire logic       haltState,
    input wire logic       waitState,
    input wire logic       globalIrqMask,
    input wire logic       timerIrq
);
    // ------------------------------------------------------------
    // control shadow and sequences
    // ------------------------------------------------------------
    logic [7:0] ctrl1Shadow;
    always_ff @(posedge core_clk) begin
        if (rst)
            ctrl1Shadow <= CTRL_RESET;
        else if (regWr && regAddr == CTRL1_ADDR)
            ctrl1Shadow <= regWrData;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_stat;
        regRd && regAddr == STATUS_ADDR;
    endsequence
    sequence s_ovf;
        s_stat ##1 regRdData[STAT_OVF_BIT];
    endsequence
    sequence s_reload;
        regWr && regAddr == CNT_LO_ADDR ##[1:2] regRd && regAddr == CNT_HI_ADDR;
    endsequence
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_quiet: assert property ($fell(rst) |-> regRdData == 8'h00 && !timerIrq)
        else $error("output active after reset");
    a_ctrl_readback: assert property (regRd && regAddr == CTRL1_ADDR |=>
        (regRdData & 8'ha2) == ($past(ctrl1Shadow) & 8'ha2)) else $error("ctrl1 readback");
    a_irq_masked: assert property (globalIrqMask |-> !timerIrq)
        else $error("irq while masked");
    a_irq_enable_gate: assert property (timerIrq |-> (ctrl1Shadow & 8'ha0) != 8'h00)
        else $error("irq without enable");
    a_reload_high: assert property (s_reload |=> regRdData == 8'hff)
        else $error("reload high byte");
    a_ovf_clear: assert property (s_ovf ##[0:4] (regRd || regWr) && regAddr == CNT_LO_ADDR
        ##[1:6] s_stat |=> !regRdData[STAT_OVF_BIT]) else $error("overflow flag kept");
    a_alt_keeps_flag: assert property (s_ovf ##1 regRd && regAddr == ACNT_LO_ADDR
        ##2 s_stat |=> regRdData[STAT_OVF_BIT]) else $error("alt read cleared flag");
    a_ovf_irq_raise: assert property (s_ovf ##0 ctrl1Shadow[CTRL1_OVFIE_BIT]
        && !globalIrqMask |-> timerIrq) else $error("overflow irq missing");
    a_cap_irq_raise: assert property (s_stat ##1 regRdData[STAT_CAP1_BIT]
        && ctrl1Shadow[CTRL1_CAPIE_BIT] && !globalIrqMask |-> timerIrq) else $error("capture irq");
endmodule : free_running_timer_monitor

bind free_running_timer free_running_timer_monitor mon (.core_clk(core_clk), .rst(rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .extCountClockPin(extCountClockPin),
    .captureInputPin1(captureInputPin1), .captureInputPin2(captureInputPin2),
    .haltState(haltState), .waitState(waitState), .globalIrqMask(globalIrqMask),
    .timerIrq(timerIrq));

/* File: bench/frt_pin_model.sv */
/* pin-side model: external count clock and two capture inputs.
   assumes its task is called at a rising edge of core_clk. */
`timescale 1ns/1ps
module frt_pin_model (
    input  wire logic core_clk,
    output logic      extCountClockPin,
    output logic      captureInputPin1,
    output logic      captureInputPin2
);
    initial {extCountClockPin, captureInputPin1, captureInputPin2} = 3'b000;
    // ------------------------------------------------------------
    // pin toggling: 0 count clock, 1 and 2 capture inputs
    // ------------------------------------------------------------
    // six quiet cycles after each edge keep active edges well apart
    task automatic toggle(input int which);
        @(posedge core_clk);
        if (which == 0)
            extCountClockPin <= ~extCountClockPin;
        else if (which == 1)
            captureInputPin1 <= ~captureInputPin1;
        else
            captureInputPin2 <= ~captureInputPin2;
        repeat (6) @(posedge core_clk);
    endtask : toggle
endmodule : frt_pin_model

/* File: bench/tb.sv */
/* self-checking bench for free_running_timer with a counter model.
   assumes frt_pkg, the pin model and the bound monitor are compiled. */
`timescale 1ns/1ps
module tb;
    import frt_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWrData = 8'h00;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        haltState = 1'b0;
    logic        waitState = 1'b0;
    logic        globalIrqMask = 1'b0;
    logic [7:0]  regRdData, d, base, rd2, d2;
    logic        timerIrq, extPin, cap1Pin, cap2Pin;
    logic [15:0] cnt;
    integer      mismatches = 0, compares = 0, seed = 32'hf9a004d8, i;
    logic [7:0]  modeCtrl[4] = '{8'h00, 8'h04, 8'h08, 8'h04};
    int          modeDiv[4] = '{4, 2, 8, 0};
    always #5 core_clk = ~core_clk;
    free_running_timer dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .extCountClockPin(extPin), .captureInputPin1(cap1Pin), .captureInputPin2(cap2Pin),
        .haltState(haltState), .waitState(waitState), .globalIrqMask(globalIrqMask),
        .timerIrq(timerIrq));
    // a second copy without bonded count clock and second capture pin
    free_running_timer #(.HAS_EXT_COUNT_CLOCK_PIN(1'b0), .HAS_CAP2(1'b0)) dut2 (.core_clk(core_clk),
        .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(rd2), .extCountClockPin(extPin), .captureInputPin1(cap1Pin),
        .captureInputPin2(cap2Pin), .haltState(haltState), .waitState(waitState),
        .globalIrqMask(globalIrqMask), .timerIrq());
    frt_pin_model pins (.core_clk(core_clk), .extCountClockPin(extPin),
        .captureInputPin1(cap1Pin), .captureInputPin2(cap2Pin));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        compares++;
        if (seen !== want) begin
            mismatches++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    // a zero mask turns the read into a plain fetch into d
    task automatic rd(input logic [3:0] a, input logic [7:0] want, input logic [7:0] mask = 8'hff);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdData;
        d2 = rd2;
        check(d & mask, want & mask);
        @(posedge core_clk);
    endtask : rd
    // model counts falling edges only, the edge select is left at zero
    task automatic ext(input int n);
        repeat (n) begin
            pins.toggle(0);
            if (extPin == 1'b0)
                cnt = cnt + 16'h0001;
        end
    endtask : ext
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : finish_test
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(CTRL1_ADDR, CTRL_RESET);
        rd(STATUS_ADDR, 8'h00);
        rd(4'hf, 8'h00);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            wr(CTRL2_ADDR, modeCtrl[i]);
            haltState <= (modeDiv[i] == 0);
            waitState <= 1'($random(seed));
            rd(CNT_LO_ADDR, 8'h00, 8'h00);
            base = d;
            repeat (62) @(posedge core_clk);
            rd(CNT_LO_ADDR, base + ((modeDiv[i] == 0) ? 8'h00 : 8'(64 / modeDiv[i])));
        end
        haltState <= 1'b0;
        rd(STATUS_ADDR, 8'h00, 8'h00);
        rd(CNT_LO_ADDR, 8'h00, 8'h00);
        $display("test prescaler done");
        wr(CTRL2_ADDR, 8'h0c);
        wr(CTRL1_ADDR, 8'ha2);
        wr(CNT_LO_ADDR, 8'($random(seed)));
        cnt = COUNT_RELOAD;
        rd(CNT_HI_ADDR, cnt[15:8]);
        ext(2);
        rd(CNT_HI_ADDR, cnt[15:8]);
        rd(CNT_LO_ADDR, 8'hfc);
        rd(ACNT_LO_ADDR, cnt[7:0]);
        rd(STATUS_ADDR, 8'h00);
        ext(6);
        rd(STATUS_ADDR, 8'h20);
        check(timerIrq, 1'b1);
        globalIrqMask <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(timerIrq, 1'b0);
        globalIrqMask <= 1'b0;
        rd(STATUS_ADDR, 8'h20);
        rd(ACNT_LO_ADDR, cnt[7:0]);
        rd(STATUS_ADDR, 8'h20);
        check(timerIrq, 1'b1);
        rd(CNT_LO_ADDR, cnt[7:0]);
        rd(STATUS_ADDR, 8'h00);
        check(timerIrq, 1'b0);
        $display("test counter done");
        ext(2);
        pins.toggle(1);
        rd(STATUS_ADDR, 8'h80);
        check(timerIrq, 1'b1);
        rd(CAP1_HI_ADDR, cnt[15:8]);
        rd(CAP1_LO_ADDR, cnt[7:0]);
        pins.toggle(2);
        rd(STATUS_ADDR, 8'h00);
        pins.toggle(2);
        rd(STATUS_ADDR, 8'h10);
        rd(CAP2_HI_ADDR, cnt[15:8]);
        base = cnt[7:0];
        ext(2);
        repeat (2) pins.toggle(2);
        rd(CAP2_LO_ADDR, base);
        repeat (2) pins.toggle(2);
        rd(CAP2_HI_ADDR, cnt[15:8]);
        rd(CAP2_LO_ADDR, cnt[7:0]);
        haltState <= 1'b1;
        repeat (2) pins.toggle(1);
        rd(STATUS_ADDR, 8'h00, 8'h80);
        haltState <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(STATUS_ADDR, 8'h80, 8'h80);
        rd(CAP1_HI_ADDR, cnt[15:8]);
        rd(CAP1_LO_ADDR, cnt[7:0]);
        $display("test capture done");
        rd(CNT_LO_ADDR, cnt[7:0]);
        check(d2, COUNT_RELOAD[7:0]);
        rd(CAP2_LO_ADDR, cnt[7:0]);
        check(d2, 8'h00);
        $display("test absent pins done");
        finish_test();
    end
    // the tests need some 500 cycles; 25000 means a hang
    initial begin
        #250000;
        mismatches++;
        finish_test();
    end
endmodule : tb
